// file: core/saio_pkg.sv
// package for the stepper axis auxiliary io block: register map, fields, types
// assumes a 32-bit APB slave at 25 MHz and two stepper axes
// What this block does
// R1 - home input sets axis zero reference
// R2 - driver reports faults on fault input
// R3 - status word mirrors live fault level
// R4 - fault with shutdown enabled turns axis off
// R5 - after shutdown, need fault clear plus re-enable
// R6 - current output released after reset, floats high
// R7 - full current select sinks line low
// R8 - two axes, fully independent state
// R9 - driver enable low while axis enabled
// R10 - two-flop synchronise home and fault inputs
package saio_pkg;
    localparam int NUM_AXES = 2;
    localparam int POS_W = 32;
    // byte offsets of the register words
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_POS0 = 8'h10;
    localparam logic [7:0] OFF_POS1 = 8'h14;
    // control word: per axis a byte at AXIS_STRIDE*axis
    localparam int AXIS_STRIDE = 8;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SHUTDOWN_EN_BIT = 1;
    localparam int CTRL_FULL_CUR_BIT = 2;
    // status word per axis byte
    localparam int STAT_HOME_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_ENABLED_BIT = 2;
    localparam int STAT_SHUTDOWN_BIT = 3;
    localparam int STAT_HOMED_BIT = 4;
    // interrupt events per axis byte
    localparam int EVT_HOME_BIT = 0;
    localparam int EVT_FAULT_BIT = 1;
    localparam int EVT_SHUTDOWN_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;

    typedef struct packed {
        logic enableReq;
        logic shutdownEn;
        logic fullCurrent;
    } saio_axis_ctrl_t;

    typedef struct packed {
        logic home;
        logic fault;
        logic enabled;
        logic shutdown;
        logic homed;
        logic homeEvt;
        logic faultEvt;
        logic shutdownEvt;
    } saio_axis_stat_t;
endpackage : saio_pkg

// file: core/saio_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes inputs come from opto isolators outside the clk_sys domain
`timescale 1ns/1ps
module saio_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic [WIDTH-1:0] pinIn, // raw pin level
    output logic [WIDTH-1:0] syncOut // synchronised level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_syncOut;

    always_comb begin
        next_stage1 = pinIn;
        next_syncOut = stage1;
    end

    // R10 two flop stages
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= next_stage1;
            syncOut <= next_syncOut;
        end
    end
endmodule : saio_sync

// file: core/saio_axis.sv
// one axis of auxiliary io: home, drive fault shutdown, current select
// assumes home and fault are already synchronised, active high
`timescale 1ns/1ps
module saio_axis (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // async reset, active low
    input wire saio_pkg::saio_axis_ctrl_t ctrl, // software control bits
    input wire logic homeSync, // synchronised home level
    input wire logic faultSync, // synchronised fault level
    input wire logic limitTrip, // limit error from motion logic
    output saio_pkg::saio_axis_stat_t stat, // status and event pulses
    output logic motionAllowed, // gate for pulse generation
    output logic zeroPos, // one-cycle zero reference pulse
    output logic drvEnableOe, // driver enable sink active
    output logic curSelOe // current select sink active
);
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_SHUT} saio_state_t;
    saio_state_t state;
    saio_state_t next_state;
    logic homePrev;
    logic faultPrev;
    logic homed;
    logic enPrev;
    logic next_homed;
    logic homeRise;
    logic faultRise;
    logic enRise;

    always_comb begin
        homeRise = homeSync && !homePrev;
        faultRise = faultSync && !faultPrev;
        enRise = ctrl.enableReq && !enPrev;
        next_homed = homed || homeRise;
        next_state = state;
        case (state)
            ST_OFF: begin
                if (ctrl.enableReq && !faultSync && !limitTrip)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                // R4 fault shutdown
                if (ctrl.shutdownEn && faultSync)
                    next_state = ST_SHUT;
                else if (!ctrl.enableReq || limitTrip)
                    next_state = ST_OFF;
            end
            ST_SHUT: begin
                // R5 needs clear fault then fresh enable edge
                if (!faultSync && enRise && !limitTrip)
                    next_state = ST_RUN;
            end
            default: next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_OFF;
            homePrev <= 1'b0;
            faultPrev <= 1'b0;
            enPrev <= 1'b0;
            homed <= 1'b0;
        end else begin
            state <= next_state;
            homePrev <= homeSync;
            faultPrev <= faultSync;
            enPrev <= ctrl.enableReq;
            homed <= next_homed;
        end
    end

    always_comb begin
        motionAllowed = (state == ST_RUN);
        // R1 home edge zeroes position
        zeroPos = homeRise;
        // R9 enable sinks low while running
        drvEnableOe = (state == ST_RUN);
        // R6 R7 sink only with full current
        curSelOe = ctrl.fullCurrent;
        // R3 live fault level
        stat.fault = faultSync;
        stat.home = homeSync;
        stat.enabled = (state == ST_RUN);
        stat.shutdown = (state == ST_SHUT);
        stat.homed = homed;
        stat.homeEvt = homeRise;
        stat.faultEvt = faultRise;
        stat.shutdownEvt = (state == ST_RUN) && (next_state == ST_SHUT);
    end
endmodule : saio_axis

// file: core/saio_top.sv
// top of the stepper auxiliary io block: APB registers, sync, two axes
// assumes position steps come from a pulse generator on the same clock
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module saio_top (
    input wire logic clk_sys, // 25 MHz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [1:0] homePin, // home inputs, active high
    input wire logic [1:0] faultPin, // drive fault inputs, active high
    input wire logic [1:0] limitTrip, // limit error per axis
    input wire logic [1:0] stepPulse, // one step event per axis
    input wire logic [1:0] stepDir, // 1 counts up
    output logic [1:0] motionAllowed, // per axis motion gate
    output logic [1:0] drvEnableOe, // driver enable sinking
    output logic [1:0] curSelOe, // current select sinking
    output logic irq // level interrupt
);
    localparam int N = saio_pkg::NUM_AXES;
    localparam int S = saio_pkg::AXIS_STRIDE;
    logic [31:0] ctrlReg;
    logic [31:0] next_ctrlReg;
    logic [31:0] irqStat;
    logic [31:0] next_irqStat;
    logic [31:0] irqMask;
    logic [31:0] next_irqMask;
    logic [31:0] statWord;
    logic [31:0] evtWord;
    logic [31:0] next_prdata;
    logic [saio_pkg::POS_W-1:0] pos [N];
    logic [saio_pkg::POS_W-1:0] next_pos [N];
    logic [1:0] homeSync;
    logic [1:0] faultSync;
    logic [1:0] zeroPos;
    logic wrEn;
    logic rdEn;
    logic addrOk;
    saio_pkg::saio_axis_stat_t axStat [N];

    saio_sync #(.WIDTH(4)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn({faultPin, homePin}),
        .syncOut({faultSync, homeSync})
    );

    // R8 independent axis instances
    for (genvar a = 0; a < N; a++) begin : g_axis
        saio_pkg::saio_axis_ctrl_t axCtrl;
        always_comb begin
            axCtrl.enableReq = ctrlReg[a*S + saio_pkg::CTRL_ENABLE_BIT];
            axCtrl.shutdownEn = ctrlReg[a*S + saio_pkg::CTRL_SHUTDOWN_EN_BIT];
            axCtrl.fullCurrent = ctrlReg[a*S + saio_pkg::CTRL_FULL_CUR_BIT];
        end
        saio_axis u_axis (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .ctrl(axCtrl),
            .homeSync(homeSync[a]),
            .faultSync(faultSync[a]),
            .limitTrip(limitTrip[a]),
            .stat(axStat[a]),
            .motionAllowed(motionAllowed[a]),
            .zeroPos(zeroPos[a]),
            .drvEnableOe(drvEnableOe[a]),
            .curSelOe(curSelOe[a])
        );
        always_comb begin
            statWord[a*S +: S] = '0;
            statWord[a*S + saio_pkg::STAT_HOME_BIT] = axStat[a].home;
            // R3 fault bit in status
            statWord[a*S + saio_pkg::STAT_FAULT_BIT] = axStat[a].fault;
            statWord[a*S + saio_pkg::STAT_ENABLED_BIT] = axStat[a].enabled;
            statWord[a*S + saio_pkg::STAT_SHUTDOWN_BIT] = axStat[a].shutdown;
            statWord[a*S + saio_pkg::STAT_HOMED_BIT] = axStat[a].homed;
            evtWord[a*S +: S] = '0;
            evtWord[a*S + saio_pkg::EVT_HOME_BIT] = axStat[a].homeEvt;
            evtWord[a*S + saio_pkg::EVT_FAULT_BIT] = axStat[a].faultEvt;
            evtWord[a*S + saio_pkg::EVT_SHUTDOWN_BIT] = axStat[a].shutdownEvt;
        end
        always_comb begin
            next_pos[a] = pos[a];
            // R1 home wins over a same-cycle step
            if (zeroPos[a])
                next_pos[a] = saio_pkg::POS_RESET;
            else if (stepPulse[a] && motionAllowed[a])
                next_pos[a] = stepDir[a] ? pos[a] + 32'h0000_0001 : pos[a] - 32'h0000_0001;
        end
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b)
                pos[a] <= saio_pkg::POS_RESET;
            else
                pos[a] <= next_pos[a];
        end
    end
    for (genvar b = N*S; b < 32; b++) begin : g_pad
        assign statWord[b] = 1'b0;
        assign evtWord[b] = 1'b0;
    end

    // zero-wait slave: access phase always completes in one cycle
    always_comb begin
        pready = 1'b1;
        addrOk = (paddr == saio_pkg::OFF_CTRL) || (paddr == saio_pkg::OFF_STATUS)
            || (paddr == saio_pkg::OFF_IRQ_STAT) || (paddr == saio_pkg::OFF_IRQ_MASK)
            || (paddr == saio_pkg::OFF_POS0) || (paddr == saio_pkg::OFF_POS1);
        pslverr = psel && penable && !addrOk;
        wrEn = psel && penable && pwrite && addrOk;
        rdEn = psel && !penable && !pwrite;
    end

    always_comb begin
        next_ctrlReg = ctrlReg;
        next_irqMask = irqMask;
        next_prdata = prdata;
        // set beats write-one clear in the same cycle
        next_irqStat = irqStat;
        if (wrEn && paddr == saio_pkg::OFF_IRQ_STAT)
            next_irqStat = irqStat & ~pwdata;
        next_irqStat = next_irqStat | evtWord;
        if (wrEn && paddr == saio_pkg::OFF_CTRL)
            next_ctrlReg = pwdata;
        if (wrEn && paddr == saio_pkg::OFF_IRQ_MASK)
            next_irqMask = pwdata;
        if (rdEn) begin
            case (paddr)
                saio_pkg::OFF_CTRL: next_prdata = ctrlReg;
                saio_pkg::OFF_STATUS: next_prdata = statWord;
                saio_pkg::OFF_IRQ_STAT: next_prdata = irqStat;
                saio_pkg::OFF_IRQ_MASK: next_prdata = irqMask;
                saio_pkg::OFF_POS0: next_prdata = pos[0];
                saio_pkg::OFF_POS1: next_prdata = pos[1];
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            // R6 current select released at reset
            ctrlReg <= saio_pkg::CTRL_RESET;
            irqStat <= 32'h0000_0000;
            irqMask <= saio_pkg::MASK_RESET;
            prdata <= 32'h0000_0000;
        end else begin
            ctrlReg <= next_ctrlReg;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
            prdata <= next_prdata;
        end
    end

    assign irq = |(irqStat & irqMask);
endmodule : saio_top

// file: tb/saio_checker.sv
// checker bound to saio_top: pin gates, status and bus error
// assumes the port names of saio_top
`timescale 1ns/1ps
module saio_checker (
    input wire logic clk_sys, // clock
    input wire logic rst_b, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // direction
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr, // bus error
    input wire logic [1:0] faultPin, // fault pins
    input wire logic [1:0] limitTrip, // limit errors
    input wire logic [1:0] motionAllowed, // motion gates
    input wire logic [1:0] drvEnableOe, // enable sinks
    input wire logic [1:0] curSelOe // current sinks
);
    logic [31:0] ctl;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // shadow of the control word, same edge as the design
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) ctl <= 32'h0;
        else if (psel && penable && pwrite && paddr == saio_pkg::OFF_CTRL) ctl <= pwdata;
    end
    sequence s_held(x);
        x [*5];
    endsequence
    a_bad_addr: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 8'h14)) else $error("bus error wrong");
    for (genvar g = 0; g < 2; g++) begin : gAxis
        a_fault_shut: assert property (s_held(faultPin[g] && ctl[8*g+1]) |->
            !motionAllowed[g]) else $error("fault did not stop axis");
        a_restart_clean: assert property ($rose(motionAllowed[g]) |->
            !$past(faultPin[g], 3)) else $error("axis started under fault");
        a_motion_gate: assert property (motionAllowed[g] |->
            $past(ctl[8*g] && !limitTrip[g])) else $error("axis runs unenabled");
        a_drv_limit: assert property (limitTrip[g] [*2] |-> !drvEnableOe[g])
            else $error("driver enabled on limit");
        a_drv_off: assert property (!ctl[8*g] [*3] |-> !drvEnableOe[g])
            else $error("driver enabled while off");
        a_cur_select: assert property (curSelOe[g] == ctl[8*g+2])
            else $error("current select wrong");
        a_stat_fault: assert property (psel && penable && !pwrite
            && paddr == saio_pkg::OFF_STATUS |-> prdata[8*g+1] == $past(faultPin[g], 3))
            else $error("status fault bit wrong");
    end
endmodule : saio_checker
bind saio_top saio_checker saio_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pslverr(pslverr), .faultPin(faultPin), .limitTrip(limitTrip),
    .motionAllowed(motionAllowed), .drvEnableOe(drvEnableOe), .curSelOe(curSelOe));

// file: tb/saio_drv_model.sv
// stepper driver model: fault output, full current input
// assumes pull-ups on the driver side of the sunk lines
`timescale 1ns/1ps
module saio_drv_model (
    input wire logic clk_sys, // clock
    input wire logic [1:0] curSelOe, // current lines sunk
    input wire logic [1:0] faultCmd, // fault ordered by bench
    output logic [1:0] faultPin, // fault outputs
    output logic [1:0] fullCur // driver in full current
);
    logic [1:0] held = 2'h0;
    // released line floats high, so half current
    assign fullCur = ~(~curSelOe);
    always @(posedge clk_sys) held <= faultCmd;
    assign faultPin = held;
endmodule : saio_drv_model

// file: tb/stepper_axis_aux_io_bench.sv
// bench for saio_top with a driver model and the bound checker
// assumes 25 MHz clock; reads are compared from a queue
`timescale 1ns/1ps
module stepper_axis_aux_io_bench;
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, pos, v;
    logic [1:0] homePin = 2'h0, faultCmd = 2'h0, limitTrip = 2'h0, stepPulse = 2'h0;
    logic [1:0] stepDir = 2'h3, faultPin, motionAllowed, drvEnableOe, curSelOe, fullCur;
    logic [63:0] expQ[$];
    logic [63:0] e;
    int checks = 0, n_mismatch = 0, cyc = 0;
    saio_top saio_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .homePin(homePin),
        .faultPin(faultPin), .limitTrip(limitTrip), .stepPulse(stepPulse),
        .stepDir(stepDir), .motionAllowed(motionAllowed), .drvEnableOe(drvEnableOe),
        .curSelOe(curSelOe), .irq(irq));
    saio_drv_model saio_drv_model_inst (.clk_sys(clk_sys), .curSelOe(curSelOe),
        .faultCmd(faultCmd), .faultPin(faultPin), .fullCur(fullCur));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic results;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so two calls never rewrite psel in one step
        @(posedge clk_sys);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        expQ.push_back({m, x});
        apb(a, 1'b0, 32'h0);
    endtask : rd
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
        if (psel && penable && pready && !pwrite) begin
            e = expQ.pop_front();
            chk(prdata & e[63:32], e[31:0]); // read data
        end
    end
    initial begin
        v = $urandom(32'hB6A55111);
        tick(16);
        rst_b <= 1'b1;
        tick(1);
        rd(saio_pkg::OFF_CTRL, 32'hFFFFFFFF, saio_pkg::CTRL_RESET); // reset value
        rd(saio_pkg::OFF_IRQ_MASK, 32'hFFFFFFFF, saio_pkg::MASK_RESET);
        chk(32'(fullCur), 32'h0); // half current
        for (int i = 0; i < 6; i++) begin
            v = $urandom & 32'h0707;
            apb(saio_pkg::OFF_CTRL, 1'b1, v);
            rd(saio_pkg::OFF_CTRL, 32'h0707, v); // own bytes
            chk(32'(fullCur), {30'h0, v[10], v[2]}); // full current
            chk(32'(drvEnableOe), {30'h0, v[8], v[0]}); // driver enable
        end
        apb(saio_pkg::OFF_CTRL, 1'b1, 32'h0103);
        limitTrip <= 2'h1;
        tick(2);
        chk(32'(drvEnableOe), 32'h2); // limit release
        limitTrip <= 2'h0;
        faultCmd <= 2'h3;
        tick(6);
        chk(32'(motionAllowed), 32'h2); // shutdown one axis
        rd(saio_pkg::OFF_STATUS, 32'h0A0A, 32'h020A); // fault status
        apb(saio_pkg::OFF_CTRL, 1'b1, 32'h0102);
        apb(saio_pkg::OFF_CTRL, 1'b1, 32'h0103);
        faultCmd <= 2'h0;
        tick(6);
        chk(32'(motionAllowed), 32'h2); // needs re-enable
        apb(saio_pkg::OFF_CTRL, 1'b1, 32'h0102);
        apb(saio_pkg::OFF_CTRL, 1'b1, 32'h0103);
        tick(2);
        chk(32'(motionAllowed), 32'h3); // restart
        rd(saio_pkg::OFF_IRQ_STAT, 32'h0707, 32'h0206);
        chk(32'(irq), 32'h0);
        apb(saio_pkg::OFF_IRQ_MASK, 1'b1, 32'h0200);
        tick(1);
        chk(32'(irq), 32'h1);
        apb(saio_pkg::OFF_IRQ_STAT, 1'b1, 32'h0200);
        tick(1);
        chk(32'(irq), 32'h0);
        pos = 32'h0;
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            stepDir <= {1'b1, v[0]};
            stepPulse <= 2'h3;
            pos = v[0] ? pos + 32'h1 : pos - 32'h1;
            tick(1);
            stepPulse <= 2'h0;
            tick(1);
        end
        rd(saio_pkg::OFF_POS0, 32'hFFFFFFFF, pos);
        homePin <= 2'h1;
        tick(4);
        rd(saio_pkg::OFF_POS0, 32'hFFFFFFFF, 32'h0); // zero on home
        rd(saio_pkg::OFF_POS1, 32'hFFFFFFFF, 32'hC); // other axis kept
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        apb(saio_pkg::OFF_CTRL, 1'b1, 32'h0404);
        chk(32'(fullCur), 32'h3); // both lines sunk
        stepPulse <= 2'h3;
        tick(1);
        stepPulse <= 2'h0;
        rd(saio_pkg::OFF_POS1, 32'hFFFFFFFF, 32'hC); // no steps while off
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        chk(32'(fullCur), 32'h0); // after reset
        results();
    end
endmodule : stepper_axis_aux_io_bench
